// ===== core/dppc_map.svh
// constants for the downstream port power control block
`ifndef DPPC_MAP_SVH
`define DPPC_MAP_SVH

// number of downstream ports, each with its own control pin
`define DPPC_NUM_PORTS 6
// channel index of the shared (ganged) control pin
`define DPPC_GANG_CH 6
// total channels: six port pins plus the shared pin
`define DPPC_NUM_CH 7
// core clock period in ns (25 MHz)
`define DPPC_CLK_NS 40
// least time the pull-up needs to raise a released pin, in ns
`define DPPC_SETTLE_NS 1000
// settle time in clock cycles, rounded up
`define DPPC_SETTLE_CYC \
  ((`DPPC_SETTLE_NS + `DPPC_CLK_NS - 1) / `DPPC_CLK_NS)
// width of the settle counter
`define DPPC_CNT_W 5
// idle level of a synchronised pin: pulled high
`define DPPC_PIN_IDLE 1'b1
// level the device drives onto a pin to remove power
`define DPPC_PIN_DRIVE_LVL 1'b0

`endif

// ===== core/dppc_pkg.sv
// types shared by the downstream port power control block
package dppc_pkg;

  // per-channel power state
  typedef enum logic [1:0] {
    DPPC_OFF = 2'b00, // pin driven low, no power
    DPPC_SETTLE = 2'b01, // pin released, pull-up still rising
    DPPC_ON = 2'b10 // pin released, sensing overcurrent
  } dppc_state_t;

  // drive of the seven control pins (six ports + shared)
  typedef struct packed {
    logic [6:0] out; // driven level
    logic [6:0] oe; // high while the device drives the pin
  } dppc_pin_drv_t;

  // status reported toward the hub core
  typedef struct packed {
    logic [5:0] oc_status; // latched overcurrent per port
    logic [5:0] oc_event; // one-cycle pulse per newly sensed fault
    logic [5:0] powered; // port power granted
  } dppc_status_t;

endpackage

// ===== core/dppc_sync.sv
// two-flop synchroniser for the control pin inputs
`timescale 1ns/100ps
`include "dppc_map.svh"

module dppc_sync #(
  parameter int W = 7
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q; // first stage, read only by the second
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q; // second stage, safe to use
  logic [W-1:0] sync_d;

  // next values: plain shift, reset to the pulled-high level
  always_comb begin
    meta_d = d;
    sync_d = meta_q;
    if (rst) begin
      meta_d = {W{`DPPC_PIN_IDLE}};
      sync_d = {W{`DPPC_PIN_IDLE}};
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign q = sync_q;

endmodule

// ===== core/dppc_top.sv
// downstream port power enable and overcurrent sense for six ports
// How it works
// - one combined power/sense pin per port, six
// - enabled port: pin released, pull-up grants power
// - enabled, released pin low means overcurrent
// - disabled port: pin driven low, power removed unless ganged with any port enabled
// - ganged mode: shared pin controls all ports
`timescale 1ns/100ps
`include "dppc_map.svh"

module dppc_top
  import dppc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  // port enables from configuration and host commands
  input wire logic [5:0] port_enable,
  // ganged power control selected
  input wire logic gang_mode,
  // clear of latched overcurrent status, one bit per port
  input wire logic [5:0] oc_clear,
  // per-port combined power enable / overcurrent sense pins
  input wire logic port1_power_ocs_i,
  output logic port1_power_ocs_o,
  output logic port1_power_ocs_oe,
  input wire logic port2_power_ocs_i,
  output logic port2_power_ocs_o,
  output logic port2_power_ocs_oe,
  input wire logic port3_power_ocs_i,
  output logic port3_power_ocs_o,
  output logic port3_power_ocs_oe,
  input wire logic port4_power_ocs_i,
  output logic port4_power_ocs_o,
  output logic port4_power_ocs_oe,
  input wire logic port5_power_ocs_i,
  output logic port5_power_ocs_o,
  output logic port5_power_ocs_oe,
  input wire logic port6_power_ocs_i,
  output logic port6_power_ocs_o,
  output logic port6_power_ocs_oe,
  // shared pin used in ganged mode
  input wire logic shared_power_control_i,
  output logic shared_power_control_o,
  output logic shared_power_control_oe,
  // status toward the hub core
  output dppc_pkg::dppc_status_t status
);

  // trade-off: ganged power follows any enabled port, so a single
  // enabled port powers every connector on the shared switch
  // channel enable: ports 0..5 own pins unless ganged, the shared
  // pin carries power for all when ganged and any port is on
  function automatic logic chan_en(input int ch,
                                   input logic [5:0] en,
                                   input logic gang);
    logic r;
    r = 1'b0;
    if (ch == `DPPC_GANG_CH) begin
      r = gang & (|en);
    end else begin
      r = en[ch] & ~gang;
    end
    return r;
  endfunction

  // per-channel pin level after synchronising
  logic [6:0] pin_raw; // straight from the pads
  logic [6:0] pin_s; // two flops later

  assign pin_raw = {shared_power_control_i, port6_power_ocs_i,
                    port5_power_ocs_i, port4_power_ocs_i,
                    port3_power_ocs_i, port2_power_ocs_i,
                    port1_power_ocs_i};

  // pads are asynchronous to ref_clk, so two flops first
  // the flops reset to the pulled-high idle level, so no false
  // fault is seen while the pins settle after reset
  dppc_sync #(
    .W(`DPPC_NUM_CH)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(pin_raw),
    .q(pin_s)
  );

  // channel state and settle counters
  dppc_state_t st_q [7]; // power state per channel
  dppc_state_t st_d [7];
  logic [`DPPC_CNT_W-1:0] cnt_q [7]; // settle countdown
  logic [`DPPC_CNT_W-1:0] cnt_d [7];
  logic [6:0] oc_hit; // overcurrent sensed this cycle

  // limitation: an overcurrent never cuts power by itself; the host
  // reads the latched status and must disable the port
  // next state per channel
  always_comb begin
    for (int c = 0; c < `DPPC_NUM_CH; c++) begin
      st_d[c] = st_q[c];
      cnt_d[c] = cnt_q[c];
      oc_hit[c] = 1'b0;
      if (!chan_en(c, port_enable, gang_mode)) begin
        // disabled by configuration or host: drive low
        st_d[c] = DPPC_OFF;
        cnt_d[c] = '0;
      end else begin
        case (st_q[c])
          DPPC_OFF: begin
            // release the pin, pull-up begins to grant power
            st_d[c] = DPPC_SETTLE;
            cnt_d[c] = `DPPC_CNT_W'(`DPPC_SETTLE_CYC);
          end
          DPPC_SETTLE: begin
            // ignore the pin until the pull-up and the two sync
            // flops have caught up, else our own low looks like
            // an overcurrent
            if (cnt_q[c] == '0) begin
              st_d[c] = DPPC_ON;
            end else begin
              cnt_d[c] = cnt_q[c] - `DPPC_CNT_W'(1);
            end
          end
          DPPC_ON: begin
            // low level from the monitor is a fault
            oc_hit[c] = ~pin_s[c];
          end
          default: begin
            st_d[c] = DPPC_OFF;
            cnt_d[c] = '0;
          end
        endcase
      end
      if (rst) begin
        st_d[c] = DPPC_OFF;
        cnt_d[c] = '0;
      end
    end
  end

  // plain register bank, reset comes in through the _d terms
  // registers for channel state
  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < `DPPC_NUM_CH; c++) begin
      st_q[c] <= st_d[c];
      cnt_q[c] <= cnt_d[c];
    end
  end

  // pin drive, status and fault latching
  dppc_pin_drv_t drv_q; // pin drive, registered
  dppc_pin_drv_t drv_d;
  dppc_status_t stat_q; // status, registered
  dppc_status_t stat_d;
  logic [6:0] oc_seen_q; // fault already reported this power-on
  logic [6:0] oc_seen_d;
  logic [5:0] oc_set; // per-port set terms

  // next values for drive and status
  always_comb begin
    drv_d = drv_q;
    oc_seen_d = oc_seen_q;
    stat_d = stat_q;
    oc_set = '0;
    for (int c = 0; c < `DPPC_NUM_CH; c++) begin
      // drive low only while off; released otherwise
      drv_d.oe[c] = (st_d[c] == DPPC_OFF);
      drv_d.out[c] = `DPPC_PIN_DRIVE_LVL;
      // a fault pulses once until power is cycled
      if (st_d[c] == DPPC_OFF) begin
        oc_seen_d[c] = 1'b0;
      end else if (oc_hit[c]) begin
        oc_seen_d[c] = 1'b1;
      end
    end
    for (int p = 0; p < `DPPC_NUM_PORTS; p++) begin
      // shared-pin fault counts against every port
      oc_set[p] = (oc_hit[p] & ~oc_seen_q[p]) |
                  (oc_hit[`DPPC_GANG_CH] &
                   ~oc_seen_q[`DPPC_GANG_CH]);
      stat_d.powered[p] = (st_d[p] != DPPC_OFF) |
                          (st_d[`DPPC_GANG_CH] != DPPC_OFF);
    end
    // event pulses for one cycle, status holds until cleared
    stat_d.oc_event = oc_set;
    // set wins over a clear in the same cycle
    stat_d.oc_status = (stat_q.oc_status & ~oc_clear) |
                       oc_set;
    if (rst) begin
      // every pin held low so no port powers up during reset
      drv_d.oe = '1;
      drv_d.out = {`DPPC_NUM_CH{`DPPC_PIN_DRIVE_LVL}};
      oc_seen_d = '0;
      stat_d = '0;
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    drv_q <= drv_d;
    oc_seen_q <= oc_seen_d;
    stat_q <= stat_d;
  end

  // outputs straight from flops
  // open-drain pad: out is always low, oe alone chooses between
  // pulling the pin down and leaving it to the pull-up
  assign port1_power_ocs_o = drv_q.out[0];
  assign port1_power_ocs_oe = drv_q.oe[0];
  assign port2_power_ocs_o = drv_q.out[1];
  assign port2_power_ocs_oe = drv_q.oe[1];
  assign port3_power_ocs_o = drv_q.out[2];
  assign port3_power_ocs_oe = drv_q.oe[2];
  assign port4_power_ocs_o = drv_q.out[3];
  assign port4_power_ocs_oe = drv_q.oe[3];
  assign port5_power_ocs_o = drv_q.out[4];
  assign port5_power_ocs_oe = drv_q.oe[4];
  assign port6_power_ocs_o = drv_q.out[5];
  assign port6_power_ocs_oe = drv_q.oe[5];
  // ganged: only the shared pin is released
  assign shared_power_control_o = drv_q.out[`DPPC_GANG_CH];
  assign shared_power_control_oe = drv_q.oe[`DPPC_GANG_CH];
  assign status = stat_q;

endmodule

// ===== dv/dppc_properties.sv
// checker for the port power control block
`timescale 1ns/100ps
module dppc_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [5:0] port_enable,
  input wire logic gang_mode,
  input wire logic [5:0] oc_clear,
  input wire logic port1_power_ocs_i,
  input wire logic port1_power_ocs_o,
  input wire logic port1_power_ocs_oe,
  input wire logic port2_power_ocs_oe,
  input wire logic port4_power_ocs_oe,
  input wire logic shared_power_control_i,
  input wire logic shared_power_control_oe,
  input wire dppc_pkg::dppc_status_t status
);
  import dppc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_port_on_release: assert property (
    port_enable[0] && !gang_mode |=>
    !port1_power_ocs_oe && status.powered[0])
    else $error("enabled port pin not released");
  a_port_off_drive: assert property (
    !port_enable[0] || gang_mode |=> port1_power_ocs_oe)
    else $error("disabled port pin not driven");
  a_drive_level_low: assert property (
    port1_power_ocs_oe |-> !port1_power_ocs_o)
    else $error("driven pin not low");
  a_gang_shared_on: assert property (
    gang_mode && |port_enable |=> !shared_power_control_oe)
    else $error("shared pin not released in ganged mode");
  a_gang_ports_off: assert property (
    gang_mode |=> port2_power_ocs_oe && status.powered[1])
    else $error("port pin or power wrong in ganged mode");
  a_shared_idle_off: assert property (
    !gang_mode |=> shared_power_control_oe)
    else $error("shared pin released outside ganged mode");
  a_settle_ignored: assert property (
    $fell(port4_power_ocs_oe) |-> !status.oc_event[3] [*8])
    else $error("fault sensed during settle");
  a_event_has_cause: assert property (
    status.oc_event[0] |-> ($past(gang_mode, 3) ?
    !$past(shared_power_control_i, 3) : !$past(port1_power_ocs_i, 3)))
    else $error("event without a low pin");
  a_event_latches: assert property (
    status.oc_event[0] |-> status.oc_status[0] ##1 !status.oc_event[0])
    else $error("event not latched or not one cycle");
  a_gang_all_ports: assert property (
    status.oc_event[0] && $past(gang_mode, 4) |-> &status.oc_status)
    else $error("shared fault not latched for all");
  a_clear_status: assert property (
    oc_clear[0] |=> !status.oc_status[0] || status.oc_event[0])
    else $error("status not cleared");
endmodule
bind dppc_top dppc_properties dppc_properties_i (.ref_clk, .rst,
  .port_enable, .gang_mode, .oc_clear, .port1_power_ocs_i,
  .port1_power_ocs_o, .port1_power_ocs_oe, .port2_power_ocs_oe,
  .port4_power_ocs_oe, .shared_power_control_i,
  .shared_power_control_oe, .status);

// ===== dv/dppc_partner.sv
// model of the external power switches and current monitors
`timescale 1ns/100ps
module dppc_partner (
  input wire logic [6:0] o,
  input wire logic [6:0] oe,
  input wire logic [6:0] fault,
  output logic [6:0] pad
);
  // device drive wins, else monitor pulls low, else pull-up
  always_comb begin
    pad = (oe & o) | (~oe & ~fault);
  end
endmodule

// ===== dv/downstream_port_power_control_bench.sv
// bench for the downstream port power control block
`timescale 1ns/100ps
module downstream_port_power_control_bench;
  import dppc_pkg::*;
  logic ref_clk = 1'b0; // core clock
  logic rst = 1'b1; // held for 16 cycles
  logic [5:0] en = 6'h00; // port enables
  logic gang = 1'b0; // ganged mode
  logic [5:0] clr = 6'h00; // status clear
  logic [6:0] fault = 7'h00; // monitor pulls, bit 6 shared
  logic [6:0] o; // driven levels
  logic [6:0] oe; // drive enables
  logic [6:0] pad; // resolved pin levels
  dppc_status_t st; // status
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0; // hang guard
  always #20 ref_clk = ~ref_clk;
  dppc_top dppc_top_i (.ref_clk, .rst, .port_enable(en), .gang_mode(gang),
    .oc_clear(clr), .status(st), .port1_power_ocs_i(pad[0]),
    .port1_power_ocs_o(o[0]), .port1_power_ocs_oe(oe[0]),
    .port2_power_ocs_i(pad[1]), .port2_power_ocs_o(o[1]),
    .port2_power_ocs_oe(oe[1]), .port3_power_ocs_i(pad[2]),
    .port3_power_ocs_o(o[2]), .port3_power_ocs_oe(oe[2]),
    .port4_power_ocs_i(pad[3]), .port4_power_ocs_o(o[3]),
    .port4_power_ocs_oe(oe[3]), .port5_power_ocs_i(pad[4]),
    .port5_power_ocs_o(o[4]), .port5_power_ocs_oe(oe[4]),
    .port6_power_ocs_i(pad[5]), .port6_power_ocs_o(o[5]),
    .port6_power_ocs_oe(oe[5]), .shared_power_control_i(pad[6]),
    .shared_power_control_o(o[6]), .shared_power_control_oe(oe[6]));
  dppc_partner dppc_partner_i (.o, .oe, .fault, .pad);
  // inputs move at the falling edge only
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input string what, input logic [17:0] exp,
    input logic [17:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic t_power();
    en = 6'h3f;
    wait_cyc(2);
    chk("oe", 18'h40, oe);
    chk("pad", 18'h3f, pad);
    chk("powered", 18'h3f, st.powered);
    en = 6'h37;
    wait_cyc(1);
    chk("oe", 18'h48, oe);
    chk("o", 18'h00, o);
  endtask
  // port 4 faults while settling, port 1 once sensing
  task automatic t_fault();
    wait_cyc(30);
    en = 6'h3f;
    fault = 7'h09;
    wait_cyc(3);
    chk("oc_event", 18'h01, st.oc_event);
    wait_cyc(7);
    chk("oc_status", 18'h01, st.oc_status);
    fault = 7'h01;
    wait_cyc(30);
    chk("oc_status", 18'h01, st.oc_status);
    chk("powered", 18'h3f, st.powered);
    clr = 6'h01;
    wait_cyc(1);
    clr = 6'h00;
    wait_cyc(5);
    chk("oc_status", 18'h00, st.oc_status);
    fault = 7'h00;
  endtask
  // per-port pins ignored, shared pin faults all ports
  task automatic t_gang();
    gang = 1'b1;
    fault = 7'h02;
    wait_cyc(2);
    chk("oe", 18'h3f, oe);
    wait_cyc(30);
    chk("oc_status", 18'h00, st.oc_status);
    fault = 7'h40;
    wait_cyc(3);
    chk("oc_event", 18'h3f, st.oc_event);
    wait_cyc(2);
    chk("oc_status", 18'h3f, st.oc_status);
    chk("oc_event", 18'h00, st.oc_event);
    fault = 7'h00;
    gang = 1'b0;
    wait_cyc(2);
    chk("oe", 18'h40, oe);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // run takes about 135 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    wait_cyc(16);
    chk("oe", 18'h7f, oe);
    chk("status", 18'h0, st);
    rst = 1'b0;
    t_power();
    t_fault();
    t_gang();
    print_verdict();
  end
endmodule
